/* File: inc/backup_ctrl_pkg.sv */
package backup_ctrl_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ADDR_RESET_CTRL_TWO = 8'h00;
  localparam logic [7:0] ADDR_CONTEXT_A      = 8'h04;
  localparam logic [7:0] ADDR_CONTEXT_B      = 8'h08;
  localparam logic [7:0] ADDR_CAL_CTRL       = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h14;
  localparam logic [7:0] ADDR_MODE_STATUS    = 8'h18;
  localparam int         ADDR_W              = 8;
  localparam int         DATA_W              = 32;

  // reset control register two and event layout
  localparam int BIT_EXIT_FLAG = 0;
  localparam int BIT_LOST_FLAG = 1;
  localparam int EVENT_W       = 2;
  // calendar control layout
  localparam int BIT_CAL_EN    = 0;
  localparam int BIT_CAL_SRC   = 1;

  // reset values
  localparam logic [EVENT_W-1:0] EVENTS_NONE  = 2'h0;
  localparam logic               FLAG_SET     = 1'b1;
  localparam logic               FLAG_CLR     = 1'b0;
  localparam logic               SRC_SECONDARY = 1'b0;

  // wake-up power-on reset timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int WAKE_POR_NS   = 1000;
  localparam int WAKE_POR_CYC  =
    (WAKE_POR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W         = 16;

  // power mode states, one-hot
  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_BACKUP = 3'b010,
    ST_WAKE   = 3'b100
  } mode_e;
endpackage : backup_ctrl_pkg

/* File: inc/reg_access_if.sv */
`timescale 1ns/10ps
interface reg_access_if
  import backup_ctrl_pkg::*;
();
  logic              wr_en;  // one-cycle write strobe
  logic [ADDR_W-1:0] addr;   // byte address of the access
  logic [DATA_W-1:0] wdata;  // write data, valid with wr_en
  logic [DATA_W-1:0] rdata;  // read data for addr
  modport bus  (output wr_en, addr, wdata, input rdata);
  modport regs (input wr_en, addr, wdata, output rdata);
endinterface : reg_access_if

/* File: design/ahb_reg_slave.sv */
`timescale 1ns/10ps
module ahb_reg_slave
  import backup_ctrl_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  reg_access_if.bus              regs
);
  logic              wr_ph_q;  // write data phase
  logic              rd_ph_q;  // read data phase, first cycle
  logic [ADDR_W-1:0] addr_q;   // captured address
  logic              take;     // address phase accepted

  // nonseq or seq selected while the bus is ready
  assign take = hsel_i && htrans_i[1] && hready_i;

  // address phase capture
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      addr_q  <= '0;
    end else begin
      wr_ph_q <= take && hwrite_i;
      rd_ph_q <= take && !hwrite_i;
      if (take) begin
        addr_q <= {haddr_i[ADDR_W-1:2], 2'b00};
      end
    end
  end

  // read data flopped in the one wait cycle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      hrdata_o <= '0;
    end else if (rd_ph_q) begin
      hrdata_o <= regs.rdata;
    end
  end

  // reads take one wait state, writes none
  assign hreadyout_o = !rd_ph_q;
  assign hresp_o     = 1'b0;
  assign regs.wr_en  = wr_ph_q;
  assign regs.addr   = addr_q;
  assign regs.wdata  = hwdata_i;

  a_read_wait: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read did not answer after one wait state");
endmodule : ahb_reg_slave

/* File: design/backup_mode_ctrl.sv */
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
module backup_mode_ctrl
  import backup_ctrl_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_POR_CYC  // wake reset length in cycles
)(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        main_supply_ok_i,
  input  wire logic        backup_retain_ok_i,
  input  wire logic        backup_present_i,
  output logic             sys_por_o,
  output logic             sfr_reset_o,
  output logic             calendar_run_o,
  output logic             calendar_src_o,
  output logic             osc_pin_hold_o,
  output logic             irq_o
);
  localparam int   NSYNC    = 3;     // supply status inputs
  localparam logic SYNC_RST = 1'b1;  // supplies read as good in reset

  reg_access_if regs ();     // register access from the bus slave

  logic [NSYNC-1:0] pins_raw;  // raw supply status pins
  logic [NSYNC-1:0] sync1_q;   // first synchroniser stage
  logic [NSYNC-1:0] sync2_q;   // second synchroniser stage
  logic             main_ok;   // main supply present
  logic             retain_ok; // backup above retention level
  logic             present;   // backup above reset threshold

  mode_e            state_q;   // power mode
  mode_e            state_d;
  logic [CNT_W-1:0] wake_cnt_q;  // wake reset cycle count
  logic             exit_flag_q; // left backup mode
  logic             lost_flag_q; // backup supply lost
  logic [31:0]      ctx_a_q;     // retained context word a
  logic [31:0]      ctx_b_q;     // retained context word b
  logic             cal_en_q;    // calendar enable
  logic             cal_sel_q;   // software source choice
  logic             cal_src_q;   // source in use
  logic [EVENT_W-1:0] irq_stat_q;  // sticky events
  logic [EVENT_W-1:0] irq_mask_q;  // event enables
  logic [EVENT_W-1:0] ev;          // events this cycle
  logic             wr_rc2;      // write to reset control two
  logic             wr_ctx_a;
  logic             wr_ctx_b;
  logic             wr_cal;
  logic             wr_stat;
  logic             wr_mask;
  logic             enter_bkp;   // main supply just lost
  logic             leave_bkp;   // main supply just back
  logic             supply_loss; // lost condition in backup

  // bus slave front end; hsize is word only and not checked
  ahb_reg_slave u_slave (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .regs        (regs.bus)
  );

  // raw status pins gathered for the synchroniser loop
  assign pins_raw = {main_supply_ok_i, backup_retain_ok_i,
                     backup_present_i};

  // two-stage synchronisers, one per supply status pin; reset reads the
  // supplies as good so that release does not fake a backup exit
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        sync1_q[i] <= SYNC_RST;
        sync2_q[i] <= SYNC_RST;
      end else begin
        sync1_q[i] <= pins_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end
  assign main_ok   = sync2_q[2];
  assign retain_ok = sync2_q[1];
  assign present   = sync2_q[0];

  // write strobes per register
  assign wr_rc2   = regs.wr_en && regs.addr == ADDR_RESET_CTRL_TWO;
  assign wr_ctx_a = regs.wr_en && regs.addr == ADDR_CONTEXT_A;
  assign wr_ctx_b = regs.wr_en && regs.addr == ADDR_CONTEXT_B;
  assign wr_cal   = regs.wr_en && regs.addr == ADDR_CAL_CTRL;
  assign wr_stat  = regs.wr_en && regs.addr == ADDR_IRQ_STATUS;
  assign wr_mask  = regs.wr_en && regs.addr == ADDR_IRQ_MASK;

  assign enter_bkp   = state_q == ST_RUN && !main_ok;
  assign leave_bkp   = state_q == ST_BACKUP && main_ok;
  // main supply gone and backup drained or missing
  assign supply_loss = state_q == ST_BACKUP && (!retain_ok || !present);

  // power mode sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN: begin
        if (!main_ok) begin
          state_d = ST_BACKUP;
        end
      end
      // stay until the main supply returns
      ST_BACKUP: begin
        if (main_ok) begin
          state_d = ST_WAKE;
        end
      end
      // hold power-on reset its full length unless the main supply drops again, which returns to backup
      ST_WAKE: begin
        if (!main_ok) begin
          state_d = ST_BACKUP;
        end else if (wake_cnt_q == CNT_W'(WAKE_CYC - 1)) begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  // mode register; first power-up also runs the reset sequence
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= ST_WAKE;
    end else begin
      state_q <= state_d;
    end
  end

  // wake reset counter, restarted on every entry to wake
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wake_cnt_q <= '0;
    end else if (state_q != ST_WAKE) begin
      wake_cnt_q <= '0;
    end else begin
      wake_cnt_q <= wake_cnt_q + CNT_W'(1);
    end
  end

  // reset outputs toward the rest of the device
  assign sys_por_o   = state_q == ST_WAKE;
  assign sfr_reset_o = state_q != ST_RUN;

  // exit flag: set on leaving backup, cleared by writing zero
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      exit_flag_q <= FLAG_CLR;
    end else if (leave_bkp) begin
      exit_flag_q <= FLAG_SET;
    end else if (wr_rc2 && !regs.wdata[BIT_EXIT_FLAG]) begin
      exit_flag_q <= FLAG_CLR;
    end
  end

  // lost flag: set at first power-up and on backup loss
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      lost_flag_q <= FLAG_SET;
    end else if (supply_loss) begin
      lost_flag_q <= FLAG_SET;
    end else if (wr_rc2 && !regs.wdata[BIT_LOST_FLAG]) begin
      lost_flag_q <= FLAG_CLR;
    end
  end

  // retained context words; lost only with the backup supply
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctx_a_q <= '0;
      ctx_b_q <= '0;
    end else if (state_q == ST_BACKUP && !retain_ok) begin
      ctx_a_q <= '0;
      ctx_b_q <= '0;
    end else begin
      if (wr_ctx_a && state_q == ST_RUN) begin
        ctx_a_q <= regs.wdata;
      end
      if (wr_ctx_b && state_q == ST_RUN) begin
        ctx_b_q <= regs.wdata;
      end
    end
  end

  // calendar control survives the wake reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cal_en_q  <= 1'b0;
      cal_sel_q <= SRC_SECONDARY;
    end else if (supply_loss) begin
      cal_en_q  <= 1'b0;  // calendar state lost with supply
    end else if (wr_cal && state_q == ST_RUN) begin
      cal_en_q  <= regs.wdata[BIT_CAL_EN];
      cal_sel_q <= regs.wdata[BIT_CAL_SRC];
    end
  end

  // source in use follows software only outside backup
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cal_src_q <= SRC_SECONDARY;
    end else if (state_q != ST_BACKUP && !enter_bkp) begin
      cal_src_q <= cal_sel_q;
    end
  end

  // calendar runs only when enabled; idle otherwise in backup
  assign calendar_run_o = cal_en_q;
  assign calendar_src_o = cal_src_q;
  // oscillator pins keep state in backup while they clock the calendar
  assign osc_pin_hold_o = state_q == ST_BACKUP && cal_en_q &&
                          cal_src_q == SRC_SECONDARY;

  // interrupt events, sticky; write one clears, set wins
  assign ev[BIT_EXIT_FLAG] = leave_bkp;
  assign ev[BIT_LOST_FLAG] = supply_loss && !lost_flag_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_stat_q <= EVENTS_NONE;
      irq_mask_q <= EVENTS_NONE;
    end else begin
      irq_stat_q <= ev | (irq_stat_q &
                    ~(wr_stat ? regs.wdata[EVENT_W-1:0] : EVENTS_NONE));
      if (wr_mask) begin
        irq_mask_q <= regs.wdata[EVENT_W-1:0];
      end
    end
  end
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // register read mux; unmapped reads as zero
  always_comb begin
    regs.rdata = '0;
    unique case (regs.addr)
      ADDR_RESET_CTRL_TWO: begin
        regs.rdata[BIT_EXIT_FLAG] = exit_flag_q;
        regs.rdata[BIT_LOST_FLAG] = lost_flag_q;
      end
      ADDR_CONTEXT_A: regs.rdata = ctx_a_q;
      ADDR_CONTEXT_B: regs.rdata = ctx_b_q;
      ADDR_CAL_CTRL: begin
        regs.rdata[BIT_CAL_EN]  = cal_en_q;
        regs.rdata[BIT_CAL_SRC] = cal_sel_q;
      end
      ADDR_IRQ_STATUS: regs.rdata[EVENT_W-1:0] = irq_stat_q;
      ADDR_IRQ_MASK:   regs.rdata[EVENT_W-1:0] = irq_mask_q;
      ADDR_MODE_STATUS: regs.rdata[2:0] = state_q;
      default: regs.rdata = '0;
    endcase
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_exit_flag_set: assert property (
    leave_bkp |=> exit_flag_q && sys_por_o)
    else $error("exit flag or wake reset missing after backup");
  a_wake_length: assert property (
    $fell(sys_por_o) && state_q == ST_RUN |->
      $past(wake_cnt_q) == CNT_W'(WAKE_CYC - 1))
    else $error("wake reset length wrong");
  a_src_frozen: assert property (
    state_q == ST_BACKUP && $past(state_q) == ST_BACKUP |->
      $stable(calendar_src_o))
    else $error("calendar source changed in backup");
  a_ctx_lost: assert property (
    state_q == ST_BACKUP && !retain_ok |=>
      lost_flag_q && ctx_a_q == '0 && ctx_b_q == '0)
    else $error("backup loss not recorded");
  a_lost_cause: assert property (
    $rose(lost_flag_q) |-> $past(supply_loss))
    else $error("lost flag set without supply loss");
  a_exit_hold: assert property (
    $fell(exit_flag_q) |-> $past(wr_rc2))
    else $error("exit flag cleared without a write");
  a_sfr_reset: assert property (
    state_q != ST_RUN |-> sfr_reset_o)
    else $error("register reset released outside run");
  a_wake_keeps: assert property (
    state_q == ST_WAKE |=> $stable(ctx_a_q) && $stable(ctx_b_q) &&
      $stable(cal_en_q) && $stable(cal_sel_q))
    else $error("wake reset disturbed retained state");
  a_cal_stays_off: assert property (
    sys_por_o && !calendar_run_o |=> !calendar_run_o)
    else $error("calendar started during wake");
  a_osc_hold: assert property (
    state_q == ST_BACKUP && calendar_run_o &&
      calendar_src_o == SRC_SECONDARY |-> osc_pin_hold_o)
    else $error("oscillator pins not held");
endmodule : backup_mode_ctrl

/* File: test/backup_mode_ctrl_bench.sv */
`timescale 1ns/10ps
module backup_mode_ctrl_bench
  import backup_ctrl_pkg::*;
;
  localparam int WK = 4;  // shortened wake reset length

  logic        ref_clk_i;           // 125 MHz clock
  logic        reset_i;             // first power-up reset
  logic        hsel_i;              // bus select
  logic [31:0] haddr_i;             // bus address
  logic [1:0]  htrans_i;            // bus transfer kind
  logic        hwrite_i;            // bus direction
  logic [2:0]  hsize_i;             // bus size, word only
  logic [31:0] hwdata_i;            // bus write data
  logic [31:0] hrdata_o;            // bus read data
  logic        hreadyout_o;         // slave ready, also bus ready
  logic        hresp_o;             // slave response
  logic        main_supply_ok_i;    // main supply present
  logic        backup_retain_ok_i;  // backup above retention level
  logic        backup_present_i;    // backup above reset threshold
  logic        sys_por_o;           // wake power-on reset
  logic        sfr_reset_o;         // other registers held in reset
  logic        calendar_run_o;      // calendar enabled
  logic        calendar_src_o;      // calendar clock source
  logic        osc_pin_hold_o;      // oscillator pins held
  logic        irq_o;               // interrupt level
  logic [31:0] rd;                  // last read value
  int          num_errors;          // mismatches seen
  int          n_tests;             // comparisons made

  backup_mode_ctrl #(.WAKE_CYC(WK)) backup_mode_ctrl_inst (
    .ref_clk_i          (ref_clk_i),
    .reset_i            (reset_i),
    .hsel_i             (hsel_i),
    .haddr_i            (haddr_i),
    .htrans_i           (htrans_i),
    .hwrite_i           (hwrite_i),
    .hsize_i            (hsize_i),
    .hwdata_i           (hwdata_i),
    .hready_i           (hreadyout_o),
    .hrdata_o           (hrdata_o),
    .hreadyout_o        (hreadyout_o),
    .hresp_o            (hresp_o),
    .main_supply_ok_i   (main_supply_ok_i),
    .backup_retain_ok_i (backup_retain_ok_i),
    .backup_present_i   (backup_present_i),
    .sys_por_o          (sys_por_o),
    .sfr_reset_o        (sfr_reset_o),
    .calendar_run_o     (calendar_run_o),
    .calendar_src_o     (calendar_src_o),
    .osc_pin_hold_o     (osc_pin_hold_o),
    .irq_o              (irq_o)
  );

  // clock generator
  initial ref_clk_i = 1'b0;
  always #4 ref_clk_i = ~ref_clk_i;

  // compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one single bus transfer; entered and left just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wr ? wd : 32'h0;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : xfer

  // read a register and compare it
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  // let some edges pass
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick

  // poll the mode status until it shows the wanted state
  task automatic wait_mode(input logic [2:0] m);
    int k;
    k = 0;
    do begin
      xfer(1'b0, ADDR_MODE_STATUS, 32'h0);
      k++;
    end while (rd[2:0] !== m && k < 200);
    check(rd, {29'h0, m});
  endtask : wait_mode

  // restore the main supply and measure the wake reset length
  task automatic wake_up;
    int k;
    int c;
    k = 0;
    c = 0;
    main_supply_ok_i <= 1'b1;
    while (sys_por_o !== 1'b1 && k < 50) begin
      @(posedge ref_clk_i);
      k++;
    end
    while (sys_por_o === 1'b1 && c < 500) begin
      @(posedge ref_clk_i);
      c++;
    end
    check(32'(c), 32'(WK));
    wait_mode(ST_RUN);
  endtask : wake_up

  // print counts and verdict, then stop
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    num_errors++;
    close_out();
  end

  // main test sequence
  initial begin
    num_errors = 0;
    n_tests = 0;
    reset_i = 1'b1;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    main_supply_ok_i = 1'b1;
    backup_retain_ok_i = 1'b1;
    backup_present_i = 1'b1;
    tick(10);
    reset_i <= 1'b0;
    wait_mode(ST_RUN);
    // first power-up: lost flag up, writing ones keeps the lost flag
    xfer(1'b0, ADDR_RESET_CTRL_TWO, 32'h0);
    check(rd, 32'h2);
    xfer(1'b1, ADDR_RESET_CTRL_TWO, 32'h3);
    xfer(1'b0, ADDR_RESET_CTRL_TWO, 32'h0);
    check({31'h0, rd[BIT_LOST_FLAG]}, 32'h1);
    xfer(1'b1, ADDR_RESET_CTRL_TWO, 32'h0);
    rd_chk(ADDR_RESET_CTRL_TWO, 32'h0);
    rd_chk(ADDR_IRQ_STATUS, 32'h0);
    xfer(1'b1, ADDR_IRQ_STATUS, 32'h3);
    xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
    rd_chk(ADDR_IRQ_STATUS, 32'h0);
    xfer(1'b1, ADDR_CONTEXT_A, 32'haaaa5555);
    xfer(1'b1, ADDR_CONTEXT_B, 32'h1234abcd);
    xfer(1'b1, ADDR_CAL_CTRL, 32'h1);
    // a missing backup while main is up must not raise the lost flag
    backup_present_i <= 1'b0;
    tick(6);
    backup_present_i <= 1'b1;
    tick(4);
    rd_chk(ADDR_RESET_CTRL_TWO, 32'h0);
    check({31'h0, calendar_run_o}, 32'h1);
    // backup with the calendar on the secondary oscillator
    main_supply_ok_i <= 1'b0;
    wait_mode(ST_BACKUP);
    check({31'h0, sfr_reset_o}, 32'h1);
    check({31'h0, osc_pin_hold_o}, 32'h1);
    xfer(1'b1, ADDR_CAL_CTRL, 32'h3);
    tick(2);
    check({31'h0, calendar_src_o}, 32'h0);
    check({31'h0, calendar_run_o}, 32'h1);
    wake_up();
    rd_chk(ADDR_RESET_CTRL_TWO, 32'h1);
    rd_chk(ADDR_CONTEXT_A, 32'haaaa5555);
    rd_chk(ADDR_CONTEXT_B, 32'h1234abcd);
    rd_chk(ADDR_CAL_CTRL, 32'h1);
    check({31'h0, sfr_reset_o}, 32'h0);
    // exit event: masked, then unmasked, then cleared
    check({31'h0, irq_o}, 32'h0);
    xfer(1'b1, ADDR_IRQ_MASK, 32'h1);
    tick(1);
    check({31'h0, irq_o}, 32'h1);
    xfer(1'b1, ADDR_IRQ_STATUS, 32'h1);
    tick(1);
    check({31'h0, irq_o}, 32'h0);
    xfer(1'b1, ADDR_RESET_CTRL_TWO, 32'h2);
    rd_chk(ADDR_RESET_CTRL_TWO, 32'h0);
    // backup with the calendar off and retention lost
    xfer(1'b1, ADDR_IRQ_MASK, 32'h3);
    // low-power source chosen in run reaches the calendar
    xfer(1'b1, ADDR_CAL_CTRL, 32'h3);
    tick(2);
    check({31'h0, calendar_src_o}, 32'h1);
    xfer(1'b1, ADDR_CAL_CTRL, 32'h0);
    main_supply_ok_i <= 1'b0;
    wait_mode(ST_BACKUP);
    check({31'h0, osc_pin_hold_o}, 32'h0);
    backup_retain_ok_i <= 1'b0;
    tick(6);
    backup_retain_ok_i <= 1'b1;
    tick(2);
    wake_up();
    rd_chk(ADDR_RESET_CTRL_TWO, 32'h3);
    rd_chk(ADDR_CONTEXT_A, 32'h0);
    rd_chk(ADDR_CONTEXT_B, 32'h0);
    check({31'h0, calendar_run_o}, 32'h0);
    rd_chk(ADDR_IRQ_STATUS, 32'h3);
    check({31'h0, irq_o}, 32'h1);
    xfer(1'b1, ADDR_IRQ_STATUS, 32'h3);
    xfer(1'b1, ADDR_RESET_CTRL_TWO, 32'h0);
    // backup below reset threshold while main is gone
    main_supply_ok_i <= 1'b0;
    wait_mode(ST_BACKUP);
    backup_present_i <= 1'b0;
    tick(6);
    backup_present_i <= 1'b1;
    tick(2);
    wake_up();
    rd_chk(ADDR_RESET_CTRL_TWO, 32'h3);
    // unmapped place and read-only mode status
    rd_chk(8'h1c, 32'h0);
    xfer(1'b1, ADDR_MODE_STATUS, 32'h0);
    rd_chk(ADDR_MODE_STATUS, {29'h0, ST_RUN});
    check({31'h0, hresp_o}, 32'h0);
    close_out();
  end
endmodule : backup_mode_ctrl_bench
